// >>> core/serdes_rx_lane_config.sv
// Purpose: Lane receiver: register file, sampling, symbol alignment and word output
// Assumes: Line pins and the line clock are asynchronous to clk and are synchronised here
// Notes:   Register reads answer one cycle after the read strobe
//
// The implementer's own choices: the plain strobed port and the register offsets.
`timescale 1ns/1ps
`include "serdes_rx_defs.svh"
`default_nettype none

module serdes_rx_lane_config (
	input  wire logic        clk,
	input  wire logic        nrst,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata,
	output logic             irq,
	input  wire logic        rx_line_pos,
	input  wire logic        rx_line_neg,
	input  wire logic        rx_line_clock,
	output logic      [9:0]  rx_parallel_word,
	output logic             rx_word_clock,
	output logic             signal_absent
);

	////////////////////////////////////////////////////////////////////////
	// Input synchronisers

	logic pos_meta_ff;
	logic pos_sync_ff;
	logic neg_meta_ff;
	logic neg_sync_ff;
	logic lclk_meta_ff;
	logic lclk_sync_ff;
	logic lclk_prev_ff;
	logic qtr_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			pos_meta_ff  <= 1'b0;
			pos_sync_ff  <= 1'b0;
			neg_meta_ff  <= 1'b0;
			neg_sync_ff  <= 1'b0;
			lclk_meta_ff <= 1'b0;
			lclk_sync_ff <= 1'b0;
			lclk_prev_ff <= 1'b0;
		end else begin
			pos_meta_ff  <= rx_line_pos;
			pos_sync_ff  <= pos_meta_ff;
			neg_meta_ff  <= rx_line_neg;
			neg_sync_ff  <= neg_meta_ff;
			lclk_meta_ff <= rx_line_clock;
			lclk_sync_ff <= lclk_meta_ff;
			lclk_prev_ff <= lclk_sync_ff;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Configuration decode

	logic [31:0]                cfg_ff;
	serdes_rx_pkg::absence_mode_t absence_mode;
	serdes_rx_pkg::lock_mode_t    lock_mode;
	serdes_rx_pkg::rate_t         rate;
	logic                         ten_bit;
	logic                         rx_on;
	logic                         lclk_rise;
	logic                         lclk_fall;
	logic                         strobe;
	logic                         sample;
	logic                         line_bit;
	logic                         nxt_qtr;

	assign absence_mode = serdes_rx_pkg::absence_mode_t'(cfg_ff[`CFG_ABSENCE_HI:`CFG_ABSENCE_LO]);
	assign lock_mode    = serdes_rx_pkg::lock_mode_t'(cfg_ff[`CFG_LOCK_HI:`CFG_LOCK_LO]);
	assign rate         = serdes_rx_pkg::rate_t'(cfg_ff[`CFG_RATE_HI:`CFG_RATE_LO]);
	assign ten_bit      = cfg_ff[`CFG_WIDTH_HI:`CFG_WIDTH_LO] == serdes_rx_pkg::WIDTH_TEN;
	assign rx_on        = cfg_ff[`CFG_ON_BIT];
	assign lclk_rise    = lclk_sync_ff & ~lclk_prev_ff;
	assign lclk_fall    = ~lclk_sync_ff & lclk_prev_ff;
	assign line_bit     = cfg_ff[`CFG_POL_BIT] ? neg_sync_ff : pos_sync_ff;

	always_comb begin
		nxt_qtr = qtr_ff;
		strobe  = 1'b0;
		unique case (rate)
			serdes_rx_pkg::RATE_FULL: begin
				strobe = lclk_rise | lclk_fall;
			end
			serdes_rx_pkg::RATE_QUARTER: begin
				strobe = lclk_rise & qtr_ff;
				if (lclk_rise) begin
					nxt_qtr = ~qtr_ff;
				end
			end
			default: begin
				strobe = lclk_rise;
			end
		endcase
	end

	assign sample = strobe & rx_on;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			qtr_ff <= 1'b0;
		end else begin
			qtr_ff <= nxt_qtr;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Deserialiser and symbol alignment

	logic [9:0] shift_ff;
	logic [3:0] idx_ff;
	logic [9:0] word_ff;
	logic [1:0] prev_low_ff;
	logic       wclk_ff;
	logic       jog_pend_ff;
	logic       lock_hi_prev_ff;
	logic [9:0] nxt_shift;
	logic [3:0] nxt_idx;
	logic [9:0] nxt_word;
	logic [1:0] nxt_prev_low;
	logic       nxt_wclk;
	logic       nxt_jog_pend;
	logic [3:0] last_idx;
	logic       comma_seen;
	logic       ev_realign;
	logic       ev_jog;

	assign last_idx   = ten_bit ? `WORD10_LAST : `WORD8_LAST;
	assign comma_seen = ({shift_ff[5:0], line_bit} == `COMMA_POS) || ({shift_ff[5:0], line_bit} == `COMMA_NEG);

	always_comb begin
		nxt_shift    = {shift_ff[8:0], line_bit};
		nxt_idx      = idx_ff;
		nxt_word     = word_ff;
		nxt_prev_low = prev_low_ff;
		nxt_wclk     = wclk_ff;
		nxt_jog_pend = jog_pend_ff;
		ev_realign   = 1'b0;
		ev_jog       = 1'b0;
		// jog armed on upper bit rise
		if (lock_mode[1] && !lock_hi_prev_ff) begin
			nxt_jog_pend = 1'b1;
		end
		// leaving for mode 00 drops a pending jog
		if (lock_mode == serdes_rx_pkg::LOCK_OFF) begin
			nxt_jog_pend = 1'b0;
		end
		if (!rx_on) begin
			nxt_shift    = 10'h000;
			nxt_idx      = 4'h0;
			nxt_word     = 10'h000;
			nxt_prev_low = 2'h0;
			nxt_wclk     = 1'b0;
			nxt_jog_pend = 1'b0;
		end else if (!sample) begin
			nxt_shift = shift_ff;
		end else if (jog_pend_ff) begin
			nxt_jog_pend = 1'b0;
			ev_jog       = 1'b1;
		end else if (lock_mode == serdes_rx_pkg::LOCK_COMMA && comma_seen &&
			idx_ff != `COMMA_END_IDX) begin
			nxt_idx    = `COMMA_NEXT_IDX;
			ev_realign = 1'b1;
		end else if (idx_ff == last_idx) begin
			nxt_idx = 4'h0;
			if (ten_bit) begin
				nxt_word = nxt_shift;
			end else begin
				nxt_word = {prev_low_ff, nxt_shift[7:0]};
			end
			nxt_prev_low = nxt_shift[1:0];
		end else begin
			nxt_idx = idx_ff + 4'h1;
		end
		// word clock high for four bits
		if (rx_on && sample) begin
			nxt_wclk = nxt_idx < `WCLK_HIGH_BITS;
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			shift_ff        <= 10'h000;
			idx_ff          <= 4'h0;
			word_ff         <= 10'h000;
			prev_low_ff     <= 2'h0;
			wclk_ff         <= 1'b0;
			jog_pend_ff     <= 1'b0;
			lock_hi_prev_ff <= 1'b0;
		end else begin
			shift_ff        <= nxt_shift;
			idx_ff          <= nxt_idx;
			word_ff         <= nxt_word;
			prev_low_ff     <= nxt_prev_low;
			wclk_ff         <= nxt_wclk;
			jog_pend_ff     <= nxt_jog_pend;
			lock_hi_prev_ff <= lock_mode[1];
		end
	end

	assign rx_parallel_word = word_ff;
	assign rx_word_clock    = wclk_ff;

	////////////////////////////////////////////////////////////////////////
	// Signal absence detector, independent of receiver_on

	logic [7:0] quiet_cnt_ff;
	logic       last_bit_ff;
	logic       absent_ff;
	logic [7:0] nxt_quiet_cnt;
	logic       nxt_last_bit;
	logic       nxt_absent;
	logic [7:0] quiet_limit;
	logic       ev_absent;

	always_comb begin
		nxt_quiet_cnt = quiet_cnt_ff;
		nxt_last_bit  = last_bit_ff;
		nxt_absent    = absent_ff;
		quiet_limit   = `ABSENT_HIGH_SAMPLES;
		if (absence_mode == serdes_rx_pkg::ABSENCE_LOW) begin
			quiet_limit = `ABSENT_LOW_SAMPLES;
		end
		// detector gated only by its field
		if (absence_mode == serdes_rx_pkg::ABSENCE_OFF) begin
			nxt_quiet_cnt = 8'h00;
			nxt_absent    = 1'b0;
		end else if (strobe) begin
			nxt_last_bit = line_bit;
			if (line_bit != last_bit_ff) begin
				nxt_quiet_cnt = 8'h00;
				nxt_absent    = 1'b0;
			end else if (quiet_cnt_ff >= quiet_limit) begin
				nxt_absent = 1'b1;
			end else begin
				nxt_quiet_cnt = quiet_cnt_ff + 8'h01;
			end
		end
	end

	assign ev_absent = nxt_absent & ~absent_ff;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			quiet_cnt_ff <= 8'h00;
			last_bit_ff  <= 1'b0;
			absent_ff    <= 1'b0;
		end else begin
			quiet_cnt_ff <= nxt_quiet_cnt;
			last_bit_ff  <= nxt_last_bit;
			absent_ff    <= nxt_absent;
		end
	end

	assign signal_absent = absent_ff;

	////////////////////////////////////////////////////////////////////////
	// Register file and interrupt

	logic [`EV_WIDTH-1:0] int_status_ff;
	logic [`EV_WIDTH-1:0] int_mask_ff;
	logic [31:0]          rdata_ff;
	logic                 irq_ff;
	logic [31:0]          nxt_cfg;
	logic [`EV_WIDTH-1:0] nxt_int_status;
	logic [`EV_WIDTH-1:0] nxt_int_mask;
	logic [31:0]          nxt_rdata;
	logic [`EV_WIDTH-1:0] events;
	logic [31:0]          status_word;

	assign events = {ev_absent, ev_jog, ev_realign};

	always_comb begin
		status_word = 32'h0000_0000;
		status_word[`STAT_ON_BIT] = rx_on;
		status_word[`STAT_ABSENT_BIT] = absent_ff;
		status_word[`STAT_PHASE_HI:`STAT_PHASE_LO] = idx_ff;
	end

	always_comb begin
		nxt_cfg        = cfg_ff;
		nxt_int_mask   = int_mask_ff;
		nxt_int_status = int_status_ff;
		nxt_rdata      = 32'h0000_0000;
		if (reg_wr) begin
			unique case (reg_addr)
				`RX_CFG_OFS: begin
					nxt_cfg = reg_wdata & `CFG_WR_MASK;
				end
				`RX_INT_STATUS_OFS: begin
					nxt_int_status = int_status_ff & ~reg_wdata[`EV_WIDTH-1:0];
				end
				`RX_INT_MASK_OFS: begin
					nxt_int_mask = reg_wdata[`EV_WIDTH-1:0];
				end
				default: begin
				end
			endcase
		end
		// New events win over a clear
		nxt_int_status = nxt_int_status | events;
		if (reg_rd) begin
			unique case (reg_addr)
				`RX_CFG_OFS: begin
					nxt_rdata = cfg_ff;
				end
				`RX_STATUS_OFS: begin
					nxt_rdata = status_word;
				end
				`RX_INT_STATUS_OFS: begin
					nxt_rdata = {{(32-`EV_WIDTH){1'b0}}, int_status_ff};
				end
				`RX_INT_MASK_OFS: begin
					nxt_rdata = {{(32-`EV_WIDTH){1'b0}}, int_mask_ff};
				end
				default: begin
					nxt_rdata = 32'h0000_0000;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_ff        <= `CFG_RESET;
			int_status_ff <= `EV_RESET;
			int_mask_ff   <= `EV_RESET;
			rdata_ff      <= 32'h0000_0000;
			irq_ff        <= 1'b0;
		end else begin
			cfg_ff        <= nxt_cfg;
			int_status_ff <= nxt_int_status;
			int_mask_ff   <= nxt_int_mask;
			rdata_ff      <= nxt_rdata;
			irq_ff        <= |(nxt_int_status & nxt_int_mask);
		end
	end

	assign reg_rdata = rdata_ff;
	assign irq       = irq_ff;

endmodule

`default_nettype wire

// >>> common/serdes_rx_defs.svh
// Purpose: Register offsets, field positions, reset values and counts of the lane receiver
// Assumes: Registers are 32-bit words at byte offsets on a plain strobe port
// Notes:   Definitions only
`ifndef SERDES_RX_DEFS_SVH
`define SERDES_RX_DEFS_SVH

// Register byte offsets
`define RX_CFG_OFS        8'h00
`define RX_STATUS_OFS     8'h04
`define RX_INT_STATUS_OFS 8'h08
`define RX_INT_MASK_OFS   8'h0c

// Configuration fields
`define CFG_ABSENCE_HI    15
`define CFG_ABSENCE_LO    14
`define CFG_LOCK_HI       13
`define CFG_LOCK_LO       12
`define CFG_POL_BIT       7
`define CFG_RATE_HI       6
`define CFG_RATE_LO       5
`define CFG_WIDTH_HI      4
`define CFG_WIDTH_LO      2
`define CFG_ON_BIT        0
`define CFG_WR_MASK       32'h007f_f7fd
`define CFG_RESET         32'h0000_0000

// Status and event bits
`define STAT_ON_BIT       0
`define STAT_ABSENT_BIT   1
`define STAT_PHASE_HI     5
`define STAT_PHASE_LO     2
`define EV_REALIGN_BIT    0
`define EV_JOG_BIT        1
`define EV_ABSENT_BIT     2
`define EV_WIDTH          3
`define EV_RESET          3'h0

// Symbol framing
`define WORD10_LAST       4'h9
`define WORD8_LAST        4'h7
`define COMMA_END_IDX     4'h6
`define COMMA_NEXT_IDX    4'h7
`define WCLK_HIGH_BITS    4'h4
`define COMMA_POS         7'h1f
`define COMMA_NEG         7'h60

// Samples without a transition before the input counts as absent
`define ABSENT_HIGH_SAMPLES 8'h20
`define ABSENT_LOW_SAMPLES  8'h40

`endif

// >>> common/serdes_rx_pkg.sv
// Purpose: Types shared by the lane receiver
// Assumes: Constants live in serdes_rx_defs.svh
// Notes:   Encodings follow the configuration fields
package serdes_rx_pkg;

	typedef enum logic [1:0] {
		ABSENCE_OFF  = 2'h0,
		ABSENCE_HIGH = 2'h1,
		ABSENCE_LOW  = 2'h2,
		ABSENCE_RSVD = 2'h3
	} absence_mode_t;

	typedef enum logic [1:0] {
		LOCK_OFF   = 2'h0,
		LOCK_COMMA = 2'h1,
		LOCK_JOG   = 2'h2,
		LOCK_RSVD  = 2'h3
	} lock_mode_t;

	typedef enum logic [1:0] {
		RATE_FULL    = 2'h0,
		RATE_HALF    = 2'h1,
		RATE_QUARTER = 2'h2,
		RATE_RSVD    = 2'h3
	} rate_t;

	typedef enum logic [2:0] {
		WIDTH_TEN   = 3'h0,
		WIDTH_EIGHT = 3'h1
	} word_width_t;

endpackage

// >>> dv/serdes_rx_lane_config_sva.sv
// Purpose: Port-level checks of the lane receiver
// Assumes: Shadow config and mask follow writes on the strobe port
// Notes:   One clock domain
`timescale 1ns/1ps
`include "serdes_rx_defs.svh"
`default_nettype none
module serdes_rx_lane_config_sva (
	input wire logic        clk,
	input wire logic        nrst,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic        irq,
	input wire logic [9:0]  rx_parallel_word,
	input wire logic        rx_word_clock,
	input wire logic        signal_absent
);
	logic [31:0] cfg_ff;
	logic [31:0] nxt_cfg;
	logic [2:0]  msk_ff;
	logic [2:0]  nxt_msk;
	logic        hit;
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	assign hit = reg_addr inside {8'h00, 8'h04, 8'h08, 8'h0c};
	always_comb begin
		nxt_cfg = cfg_ff;
		nxt_msk = msk_ff;
		if (reg_wr && reg_addr == `RX_CFG_OFS)
			nxt_cfg = reg_wdata & `CFG_WR_MASK;
		if (reg_wr && reg_addr == `RX_INT_MASK_OFS)
			nxt_msk = reg_wdata[2:0];
	end
	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cfg_ff <= 32'h0;
			msk_ff <= 3'h0;
		end else begin
			cfg_ff <= nxt_cfg;
			msk_ff <= nxt_msk;
		end
	end
	sequence s_off;
		(!cfg_ff[0]) [*3];
	endsequence
	sequence s_nomask;
		(msk_ff == 3'h0) [*3];
	endsequence
	AST_OFF_IDLE: assert property (s_off |-> rx_parallel_word == 10'h0 && !rx_word_clock)
		else $error("output while receiver off");
	AST_BYTE_TOP: assert property (cfg_ff[0] && cfg_ff[4:2] == 3'h1 && $changed(rx_parallel_word)
		|-> rx_parallel_word[9:8] == $past(rx_parallel_word[1:0]))
		else $error("byte top bits wrong");
	AST_WCLK_NEW: assert property (cfg_ff[0] && $changed(rx_parallel_word) |-> rx_word_clock)
		else $error("word clock low at new word");
	AST_RD_IDLE: assert property (!reg_rd |=> reg_rdata == 32'h0)
		else $error("read data without read");
	AST_CFG_READ: assert property (reg_rd && reg_addr == `RX_CFG_OFS |=> reg_rdata == cfg_ff)
		else $error("config readback wrong");
	AST_UNMAPPED: assert property (reg_rd && !hit |=> reg_rdata == 32'h0)
		else $error("unmapped read not zero");
	AST_IRQ_MASK: assert property (s_nomask |-> !irq)
		else $error("irq while all masked");
	AST_ABS_FIELD: assert property ($rose(signal_absent) |-> $past(cfg_ff[15:14]) != 2'h0)
		else $error("absence flagged while detection off");
endmodule
`default_nettype wire

// >>> dv/serdes_rx_far_tx.sv
// Purpose: Remote transmitter driving the receive pair
// Assumes: Line clock stands low between frames
// Notes:   One call drives one line clock edge
`timescale 1ns/1ps
`default_nettype none
module serdes_rx_far_tx (
	output logic rx_line_pos,
	output logic rx_line_neg,
	output logic rx_line_clock
);
	initial begin
		rx_line_pos = 1'b0;
		rx_line_neg = 1'b1;
		rx_line_clock = 1'b0;
	end
	task automatic edge_bit(input logic b);
		rx_line_pos <= b;
		rx_line_neg <= ~b;
		#80;
		rx_line_clock <= ~rx_line_clock;
		#80;
	endtask
	// Released pair shows stale inverse
	task automatic idle();
		rx_line_pos <= ~rx_line_pos;
		rx_line_neg <= ~rx_line_neg;
	endtask
endmodule
`default_nettype wire

// >>> dv/serdes_rx_lane_config_tb.sv
// Purpose: Self-checking bench of the lane receiver
// Assumes: Line clock 320 ns from the far transmitter model
// Notes:   Words and read data are checked from queues
`timescale 1ns/1ps
`include "serdes_rx_defs.svh"
`default_nettype none
module serdes_rx_lane_config_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic [7:0]  reg_addr = 8'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic        rd_d = 1'b0;
	logic        mon_on = 1'b0;
	logic [31:0] reg_rdata;
	logic        irq, pos, neg, lclk, wclk, absent;
	logic [9:0]  word, last_w, w, p;
	logic [9:0]  wq[$];
	logic [31:0] rq[$];
	int          num_errors = 0;
	int          samples_checked = 0;
	int          cyc = 0;
	int          r;
	always #20 clk = ~clk;
	serdes_rx_lane_config uut (.clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
		.reg_rdata, .irq, .rx_line_pos(pos), .rx_line_neg(neg), .rx_line_clock(lclk),
		.rx_parallel_word(word), .rx_word_clock(wclk), .signal_absent(absent));
	serdes_rx_far_tx far (.rx_line_pos(pos), .rx_line_neg(neg), .rx_line_clock(lclk));
	////////////////////////////////////////////////////////////////////////
	task automatic close_out();
		$display("checks %0d errors %0d", samples_checked, num_errors);
		if (num_errors == 0 && samples_checked > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		samples_checked++;
		if (got !== exp) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		rq.push_back(e);
		@(posedge clk);
		reg_rd <= 1'b0;
	endtask
	task automatic cfg(input logic [31:0] c);
		mon_on <= 1'b0;
		wr(`RX_CFG_OFS, 32'h0);
		wr(`RX_CFG_OFS, c);
		mon_on <= 1'b1;
	endtask
	// First bit sent lands in word bit 9, or in bit 7 in byte mode
	task automatic send(input logic [9:0] v, input int n, input int k);
		for (int i = n - 1; i >= 0; i--)
			repeat (k) far.edge_bit(v[i]);
		far.idle();
		repeat (8) @(posedge clk);
	endtask
	task automatic done(input string name);
		repeat (4) @(posedge clk);
		chk("pending", 32'h0, 32'(wq.size() + rq.size()));
		$display("test %s done", name);
	endtask
	////////////////////////////////////////////////////////////////////////
	always @(posedge clk) begin
		cyc <= cyc + 1;
		rd_d <= reg_rd;
		last_w <= word;
		if (rd_d)
			chk("rdata", rq.pop_front(), reg_rdata);
		if (mon_on && word !== last_w) begin
			chk("word", 32'(wq.size() ? wq.pop_front() : ~word), 32'(word));
			chk("wclk", 32'h1, 32'(wclk));
		end
		if (cyc == 20000) begin
			num_errors++;
			close_out();
		end
	end
	initial begin
		void'($urandom(87));
		repeat (20) @(posedge clk);
		nrst <= 1'b1;
		for (int a = 0; a <= 16; a += 4)
			rd(8'(a), 32'h0);
		wr(`RX_CFG_OFS, 32'h00a4);
		rd(`RX_CFG_OFS, 32'h00a4);
		wr(`RX_STATUS_OFS, 32'hffff_ffff);
		rd(`RX_STATUS_OFS, 32'h0);
		wr(`RX_INT_MASK_OFS, 32'hfff8);
		rd(`RX_INT_MASK_OFS, 32'h0);
		done("regs");
		for (int m = 0; m < 4; m++) begin
			r = (m == 3) ? 1 : m;
			cfg(32'h1 | (r << 5) | ((m == 3) << 7));
			for (int j = 0; j < 2; j++) begin
				w = 10'($urandom);
				w[9] = ~j[0] ^ (m == 3);
				wq.push_back(w ^ {10{m == 3}});
				send(w, 10, 1 << r);
			end
			done("rate");
		end
		cfg(32'h25);
		p = 10'h0;
		for (int j = 0; j < 3; j++) begin
			w = 10'($urandom);
			w[7] = ~j[0];
			wq.push_back({p[1:0], w[7:0]});
			p = w;
			send(w, 8, 2);
		end
		done("byte");
		cfg(32'h1021);
		wq.push_back(10'h0fa);
		wq.push_back(10'h155);
		send(10'h33e, 10, 2);
		send(10'h2, 2, 2);
		chk("irq", 32'h0, 32'(irq));
		wr(`RX_INT_MASK_OFS, 32'h1);
		repeat (2) @(negedge clk);
		chk("irq", 32'h1, 32'(irq));
		rd(`RX_INT_STATUS_OFS, 32'h1);
		wr(`RX_INT_STATUS_OFS, 32'h1);
		repeat (2) @(negedge clk);
		chk("irq", 32'h0, 32'(irq));
		send(10'h155, 10, 2);
		done("comma");
		cfg(32'h21);
		wr(`RX_CFG_OFS, 32'h2021);
		wr(`RX_CFG_OFS, 32'h21);
		wq.push_back(10'h3ff);
		send(10'h3ff, 10, 2);
		wr(`RX_CFG_OFS, 32'h2021);
		send(10'h0, 10, 2);
		wq.push_back(10'h0);
		send(10'h0, 1, 2);
		done("jog");
		mon_on <= 1'b0;
		for (int t = 0; t < 3; t++) begin
			wr(`RX_CFG_OFS, 32'h20 | (t << 14));
			send(10'h2aa, 4, 2);
			repeat (4) send(10'h0, 10, 2);
			chk("absent", 32'(t == 1), 32'(absent));
			repeat (3) send(10'h0, 10, 2);
			chk("absent", 32'(t != 0), 32'(absent));
		end
		rd(`RX_INT_STATUS_OFS, 32'h6);
		done("absence");
		close_out();
	end
endmodule
bind serdes_rx_lane_config serdes_rx_lane_config_sva sva_i (.clk, .nrst, .reg_addr, .reg_wdata,
	.reg_wr, .reg_rd, .reg_rdata, .irq, .rx_parallel_word, .rx_word_clock, .signal_absent);
`default_nettype wire
